// file: tcsu_pkg.sv
// Constants, register map and carrier types of the timer control/status unit
package tcsu_pkg;
  // Register byte addresses, one aligned word each
  localparam logic [5:0] OFS_CTL1 = 6'h00;
  localparam logic [5:0] OFS_MODE = 6'h04;
  localparam logic [5:0] OFS_STAT = 6'h08;
  localparam logic [5:0] OFS_CAPA_HI = 6'h0c;
  localparam logic [5:0] OFS_CAPA_LO = 6'h10;
  localparam logic [5:0] OFS_CMPA_HI = 6'h14;
  localparam logic [5:0] OFS_CMPA_LO = 6'h18;
  localparam logic [5:0] OFS_CNT_HI = 6'h1c;
  localparam logic [5:0] OFS_CNT_LO = 6'h20;
  localparam logic [5:0] OFS_ALT_HI = 6'h24;
  localparam logic [5:0] OFS_ALT_LO = 6'h28;
  localparam logic [5:0] OFS_CAPB_HI = 6'h2c;
  localparam logic [5:0] OFS_CAPB_LO = 6'h30;
  localparam logic [5:0] OFS_CMPB_HI = 6'h34;
  localparam logic [5:0] OFS_CMPB_LO = 6'h38;
  // Flag indices; status byte bit of flag i is ST_FLAG_TOP - i
  localparam int FL_CAPA = 0;
  localparam int FL_CMPA = 1;
  localparam int FL_WRAP = 2;
  localparam int FL_CAPB = 3;
  localparam int FL_CMPB = 4;
  localparam int NFLAG = 5;
  localparam int ST_FLAG_TOP = 7;
  localparam int ST_DIS = 2;
  // Low byte whose access clears each flag after a status read
  localparam logic [5:0] FLAG_LO_OFS [NFLAG] = '{OFS_CAPA_LO, OFS_CMPA_LO,
    OFS_CNT_LO, OFS_CAPB_LO, OFS_CMPB_LO};
  // Reset values and counter maximum
  localparam logic [15:0] CNT_RST = 16'hfffc;
  localparam logic [15:0] CMP_RST = 16'h8000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [7:0] CTL_RST = 8'h00;
  // Clock selection codes and prescaler ratios
  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT = 2'h3;
  localparam int PRE_DIV2 = 2;
  localparam int PRE_DIV4 = 4;
  localparam int PRE_DIV8 = 8;
  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int HTRANS_ACT_BIT = 1;

  typedef struct packed {
    logic compare1_pin_en;
    logic compare2_pin_en;
    logic one_pulse_mode;
    logic pwm_mode_en;
    logic [1:0] clk_sel;
    logic capture2_edge;
    logic ext_clk_edge;
  } tcsu_mode_t;

  typedef struct packed {
    logic capture_irq_en;
    logic compare_irq_en;
    logic wrap_irq_en;
    logic force_b;
    logic force_a;
    logic output_level2;
    logic capture1_edge;
    logic output_level1;
  } tcsu_ctl1_t;

  typedef struct packed {
    logic [5:0] ofs;
    logic wr;
    logic vld;
  } tcsu_acc_t;
endpackage : tcsu_pkg

// file: tcsu_top.sv
// Timer control/status unit: AHB-Lite registers, counter, flags and pins
//
// How it works
// - Compare-a pin driven by timer when compare1_pin_en set; matching always runs.
// - Compare-b pin driven with output_level2 when compare2_pin_en set.
// - Pulse modes put both levels on compare-a pin when enabled.
// - one_pulse_mode: capture-a edge starts one pulse; length from compare a.
// - pwm_mode_en: repeating wave, pulse from compare a, period from compare b.
// - clk_sel 00 div4, 01 div2, 10 div8, 11 external clock.
// - External clock selected but absent: counter stops.
// - capture2_edge picks capture-b edge: 0 falling, 1 rising.
// - ext_clk_edge picks counting edge of external pin: 0 falling, 1 rising.
// - capture1_flag set on capture a, or compare-b reach in pwm mode.
// - Flag clears by status read then access of its low byte.
// - compare1_flag set when counter equals compare a, except in pwm mode.
// - compare2_flag set when counter equals compare b, except in pwm mode.
// - overflow_flag set when counter wraps from ffff to zero.
// - Alternate counter low byte access never clears overflow_flag.
// - capture2_flag set on capture-b event.
// - timer_disable freezes prescaler and counter, releases both compare pins.
// - Registers stay accessible while timer_disable is set.
// - timer_disable resets to 0; flags are read-only.
// - Shared interrupt when an enabled flag is set.
// - capture1_edge picks capture-a and one-pulse trigger edge.
// - Pulse modes copy output_level2 onto compare-a pin too.
`timescale 1ns/1ps
module tcsu_top import tcsu_pkg::*; #(
  parameter bit EXT_PRESENT = 1'b1 // External count pin bonded out
) (
  input wire logic hclk, // Bus and timer clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [5:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Only word transfers used
  input wire logic hready, // Bus ready
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Low in reset, then always ready
  output logic hresp, // Always OKAY
  input wire logic capture_in_pin_a, // Capture / one-pulse trigger pin
  input wire logic capture_in_pin_b, // Capture pin b
  input wire logic external_count_pin, // External clock pin
  output logic compare_out_pin_a, // Compare-a pin level
  output logic compare_out_pin_a_oe_n, // Low while timer drives pin a
  output logic compare_out_pin_b, // Compare-b pin level
  output logic compare_out_pin_b_oe_n, // Low while timer drives pin b
  output logic timer_irq // Shared timer interrupt
);
  tcsu_ctl1_t ctl1_r;
  tcsu_mode_t mode_r;
  tcsu_acc_t acc_r;
  logic dis_r;
  logic [15:0] cnt_r, cmp_a_r, cmp_b_r, cap_a_r, cap_b_r;
  logic [NFLAG-1:0] flag_r, armed_r, flag_set, lo_hit;
  logic [2:0] sync1_r, sync2_r, sync3_r, lvl_r, lvl_nxt, rise, fall;
  logic [2:0] div_r;
  logic [7:0] wbyte, status_byte;
  logic addr_ok, wr_en, pre_tick, ext_tick, tick, restart, opm_trig;
  logic cap_a_evt, cap_b_evt, match_a, match_b, wrap, wr_cnt;
  logic [15:0] cnt_inc;

  // Prescaler end count for a clock selection
  function automatic logic [2:0] div_max(input logic [1:0] sel);
    case (sel)
      CLK_DIV2: div_max = 3'(PRE_DIV2 - 1);
      CLK_DIV8: div_max = 3'(PRE_DIV8 - 1);
      default: div_max = 3'(PRE_DIV4 - 1);
    endcase
  endfunction : div_max

  // Register read view
  function automatic logic [7:0] rd_mux(input logic [5:0] ofs);
    case (ofs)
      OFS_CTL1: rd_mux = ctl1_r;
      OFS_MODE: rd_mux = mode_r;
      OFS_STAT: rd_mux = status_byte;
      OFS_CAPA_HI: rd_mux = cap_a_r[15:8];
      OFS_CAPA_LO: rd_mux = cap_a_r[7:0];
      OFS_CMPA_HI: rd_mux = cmp_a_r[15:8];
      OFS_CMPA_LO: rd_mux = cmp_a_r[7:0];
      OFS_CNT_HI, OFS_ALT_HI: rd_mux = cnt_r[15:8];
      OFS_CNT_LO, OFS_ALT_LO: rd_mux = cnt_r[7:0];
      OFS_CAPB_HI: rd_mux = cap_b_r[15:8];
      OFS_CAPB_LO: rd_mux = cap_b_r[7:0];
      OFS_CMPB_HI: rd_mux = cmp_b_r[15:8];
      OFS_CMPB_LO: rd_mux = cmp_b_r[7:0];
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  // Address phase decode; bus access never depends on the disable bit
  assign addr_ok = hsel && htrans[HTRANS_ACT_BIT] && hready;
  assign wr_en = acc_r.vld && acc_r.wr;
  assign wbyte = hwdata[7:0];
  assign wr_cnt = wr_en && (acc_r.ofs == OFS_CNT_LO || acc_r.ofs == OFS_ALT_LO);
  // Reserved status bits read as zero whatever software wrote
  assign status_byte = {flag_r[FL_CAPA], flag_r[FL_CMPA], flag_r[FL_WRAP],
    flag_r[FL_CAPB], flag_r[FL_CMPB], dis_r, 2'h0};

  // Bus slave: zero wait states, read data sampled at the address edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= '0;
      hrdata <= 32'h0;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      acc_r <= '{ofs: haddr, wr: hwrite, vld: addr_ok};
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= {24'h0, rd_mux(haddr)};
      end
    end
  end

  // Control registers written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl1_r <= CTL_RST;
      mode_r <= CTL_RST;
      dis_r <= 1'b0;
    end else if (wr_en) begin
      case (acc_r.ofs)
        OFS_CTL1: ctl1_r <= wbyte;
        OFS_MODE: mode_r <= wbyte;
        OFS_STAT: dis_r <= wbyte[ST_DIS];
        default: ;
      endcase
    end
  end

  // Compare values, writable at any time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_a_r <= CMP_RST;
      cmp_b_r <= CMP_RST;
    end else if (wr_en) begin
      case (acc_r.ofs)
        OFS_CMPA_HI: cmp_a_r[15:8] <= wbyte;
        OFS_CMPA_LO: cmp_a_r[7:0] <= wbyte;
        OFS_CMPB_HI: cmp_b_r[15:8] <= wbyte;
        OFS_CMPB_LO: cmp_b_r[7:0] <= wbyte;
        default: ;
      endcase
    end
  end

  // Three-stage synchronisers for the pins; level accepted when 2 and 3 agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sync3_r <= 3'h0;
      lvl_r <= 3'h0;
    end else begin
      sync1_r <= {external_count_pin, capture_in_pin_b, capture_in_pin_a};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // Edge detect per pin on the filtered level
  for (genvar i = 0; i < 3; i++) begin : g_edge
    assign lvl_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : lvl_r[i];
    assign rise[i] = lvl_nxt[i] && !lvl_r[i];
    assign fall[i] = !lvl_nxt[i] && lvl_r[i];
  end

  // Event selection by edge polarity bits
  assign cap_b_evt = mode_r.capture2_edge ? rise[1] : fall[1];
  assign ext_tick = mode_r.ext_clk_edge ? rise[2] : fall[2];
  assign opm_trig = mode_r.one_pulse_mode && !dis_r &&
    (ctl1_r.capture1_edge ? rise[0] : fall[0]);
  // Capture a is taken over by the pulse modes
  assign cap_a_evt = !mode_r.one_pulse_mode && !mode_r.pwm_mode_en &&
    (ctl1_r.capture1_edge ? rise[0] : fall[0]);

  // Prescaler, frozen by disable; restarts on a mode write so a new ratio
  // never yields a short first period
  assign pre_tick = !dis_r && (div_r == div_max(mode_r.clk_sel));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r <= 3'h0;
    end else if (wr_en && acc_r.ofs == OFS_MODE) begin
      div_r <= 3'h0;
    end else if (!dis_r) begin
      div_r <= pre_tick ? 3'h0 : div_r + 3'h1;
    end
  end

  // Counter tick; absent external pin means no ticks while the external clock is selected
  assign tick = !dis_r && ((mode_r.clk_sel == CLK_EXT) ?
    (EXT_PRESENT && ext_tick) : pre_tick);
  assign cnt_inc = cnt_r + 16'h1;
  assign match_a = tick && cnt_inc == cmp_a_r;
  assign match_b = tick && cnt_inc == cmp_b_r;
  assign restart = (mode_r.pwm_mode_en && match_b) || opm_trig;
  assign wrap = tick && cnt_r == CNT_MAX && !restart;

  // Free-running counter; a counter-low write resets it, even when frozen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= CNT_RST;
    end else if (wr_cnt || restart) begin
      cnt_r <= CNT_RST;
    end else if (tick) begin
      cnt_r <= cnt_inc;
    end
  end

  // Capture registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_a_r <= 16'h0;
      cap_b_r <= 16'h0;
    end else begin
      if (cap_a_evt) begin
        cap_a_r <= cnt_r;
      end
      if (cap_b_evt) begin
        cap_b_r <= cnt_r;
      end
    end
  end

  // Flag sources; compare flags are not raised in pwm mode
  assign flag_set[FL_CAPA] = cap_a_evt ||
    (mode_r.pwm_mode_en && match_b);
  assign flag_set[FL_CMPA] = match_a && !mode_r.pwm_mode_en;
  assign flag_set[FL_WRAP] = wrap;
  assign flag_set[FL_CAPB] = cap_b_evt;
  assign flag_set[FL_CMPB] = match_b && !mode_r.pwm_mode_en;

  // Flags: status read arms, low-byte access clears; a new event wins.
  // Only flags seen set by that read are armed, so events after it survive.
  for (genvar i = 0; i < NFLAG; i++) begin : g_flag
    assign lo_hit[i] = acc_r.vld && acc_r.ofs == FLAG_LO_OFS[i];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        flag_r[i] <= 1'b0;
        armed_r[i] <= 1'b0;
      end else begin
        if (flag_set[i]) begin
          flag_r[i] <= 1'b1;
        end else if (lo_hit[i] && armed_r[i]) begin
          flag_r[i] <= 1'b0;
        end
        if (addr_ok && !hwrite && haddr == OFS_STAT) begin
          armed_r[i] <= flag_r[i];
        end else if (lo_hit[i]) begin
          armed_r[i] <= 1'b0;
        end
      end
    end
  end

  // Compare-a pin: level 1 on match, level 2 at pulse start in pulse modes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_out_pin_a <= 1'b0;
      compare_out_pin_a_oe_n <= 1'b1;
    end else begin
      compare_out_pin_a_oe_n <= !(mode_r.compare1_pin_en && !dis_r);
      if (restart) begin
        compare_out_pin_a <= ctl1_r.output_level2;
      end else if (match_a || ctl1_r.force_a) begin
        compare_out_pin_a <= ctl1_r.output_level1;
      end
    end
  end

  // Compare-b pin follows level 2 on match or force
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_out_pin_b <= 1'b0;
      compare_out_pin_b_oe_n <= 1'b1;
    end else begin
      compare_out_pin_b_oe_n <= !(mode_r.compare2_pin_en && !dis_r);
      if (match_b || ctl1_r.force_b) begin
        compare_out_pin_b <= ctl1_r.output_level2;
      end
    end
  end

  // Shared interrupt from enabled flags
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (ctl1_r.capture_irq_en &&
        (flag_r[FL_CAPA] || flag_r[FL_CAPB])) ||
        (ctl1_r.compare_irq_en && (flag_r[FL_CMPA] || flag_r[FL_CMPB])) ||
        (ctl1_r.wrap_irq_en && flag_r[FL_WRAP]);
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_wrap_sets: assert property (wrap |=> flag_r[FL_WRAP])
    else $error("wrap did not set overflow flag");
  a_cmpa_sets: assert property (flag_set[FL_CMPA] |=> flag_r[FL_CMPA])
    else $error("compare a match lost");
  a_cmpb_sets: assert property (flag_set[FL_CMPB] |=> flag_r[FL_CMPB])
    else $error("compare b match lost");
  a_capb_sets: assert property (cap_b_evt |=> flag_r[FL_CAPB] &&
    cap_b_r == $past(cnt_r))
    else $error("capture b not taken");
  a_freeze_cnt: assert property (dis_r && !wr_cnt |=>
    cnt_r == $past(cnt_r))
    else $error("counter moved while disabled");
  a_pins_released: assert property (dis_r |=> compare_out_pin_a_oe_n &&
    compare_out_pin_b_oe_n)
    else $error("compare pins driven while disabled");
  a_alt_keeps: assert property (flag_r[FL_WRAP] && acc_r.vld &&
    acc_r.ofs == OFS_ALT_LO |=> flag_r[FL_WRAP])
    else $error("alternate low access cleared overflow");
  a_clear_seq: assert property (lo_hit[FL_WRAP] && armed_r[FL_WRAP] &&
    !wrap |=> !flag_r[FL_WRAP])
    else $error("overflow flag not cleared");
  a_no_ext: assert property (!EXT_PRESENT &&
    mode_r.clk_sel == CLK_EXT && !wr_cnt |=> cnt_r == $past(cnt_r))
    else $error("counter ran without external pin");
  a_div2_rate: assert property (pre_tick &&
    mode_r.clk_sel == CLK_DIV2 |=> !pre_tick)
    else $error("prescaler ticked two cycles in a row");
  a_irq_wrap: assert property (ctl1_r.wrap_irq_en &&
    flag_r[FL_WRAP] |=> timer_irq)
    else $error("enabled overflow gave no interrupt");
  a_pwm_period: assert property (mode_r.pwm_mode_en && match_b |=>
    cnt_r == CNT_RST && flag_r[FL_CAPA])
    else $error("pwm period did not restart");

  c_wrap: cover property (wrap);
  c_pwm_cycle: cover property (mode_r.pwm_mode_en && match_b);
  c_one_pulse: cover property (opm_trig ##[1:1000] match_a);
  c_flag_clear: cover property (lo_hit[FL_CMPA] && armed_r[FL_CMPA]);
endmodule : tcsu_top

// file: tcsu_tb.sv
// Self-checking testbench of the timer control/status unit
`timescale 1ns/1ps
module tcsu_tb import tcsu_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [5:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic cap_a, cap_b, ext_pin, pa, pa_oe_n, pb, pb_oe_n, irq;
  int failures, total_checks, seed, t1, t2, t3, w;
  int cyc = 0;
  logic [7:0] v1, v2, v3, a, b, rd;
  logic [1:0] sels [3] = '{CLK_DIV4, CLK_DIV2, CLK_DIV8};
  int divs [3] = '{PRE_DIV4, PRE_DIV2, PRE_DIV8};

  tcsu_top u_tcsu_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_in_pin_a(cap_a),
    .capture_in_pin_b(cap_b), .external_count_pin(ext_pin),
    .compare_out_pin_a(pa), .compare_out_pin_a_oe_n(pa_oe_n),
    .compare_out_pin_b(pb), .compare_out_pin_b_oe_n(pb_oe_n),
    .timer_irq(irq)
  );

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Cycle count; the ceiling is well above the longest expected run
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      summarize();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Single AHB-Lite word write; waits on hready, never assumes latency
  task bus_wr(input logic [5:0] ad, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : bus_wr

  // Single AHB-Lite word read; data taken at the data-phase edge
  task bus_rd(input logic [5:0] ad, output logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata[7:0];
  endtask : bus_rd

  // Timer ticks from the reload value until the counter reads v
  function automatic int ticks_to(input logic [15:0] v);
    return int'(16'(v - CNT_RST));
  endfunction : ticks_to

  task stat_bit(input int n, input logic e, input string m);
    bus_rd(OFS_STAT, rd);
    chk(rd[n], e, m);
  endtask : stat_bit

  // Bounded wait for compare pin a to reach a level; returns the cycle
  task wait_pin(input logic lvl, output int t);
    int n;
    n = 0;
    while (pa !== lvl && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n == 3000) chk(1'b0, 1'b1, "pin a never changed");
    t = cyc;
  endtask : wait_pin

  task summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  initial begin
    seed = 20;
    failures = 0;
    total_checks = 0;
    {hsel, hwrite, cap_a, cap_b, ext_pin} = 5'h0;
    haddr = 6'h00;
    htrans = 2'h0;
    hwdata = 32'h0;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped place
    stat_bit(ST_DIS, 1'b0, "disable reset");
    chk(hresp, 1'b0, "okay response");
    bus_rd(OFS_MODE, v1);
    chk(v1, CTL_RST, "mode reset");
    bus_rd(OFS_CMPA_HI, v1);
    chk(v1, CMP_RST[15:8], "compare reset");
    bus_rd(6'h3c, v1);
    chk(v1, 8'h00, "unmapped read");
    $display("test reset done");
    // One pulse: rising trigger, level2 high then level1 low
    a = 8'(10 + {$random(seed)} % 16);
    bus_wr(OFS_CMPA_HI, 8'h00);
    bus_wr(OFS_CMPA_LO, a);
    bus_wr(OFS_CTL1, 8'h06);
    bus_wr(OFS_MODE, 8'ha4);
    cap_a <= 1'b1;
    wait_pin(1'b1, t1);
    chk(pa_oe_n, 1'b0, "pin a driven");
    wait_pin(1'b0, t2);
    w = ticks_to({8'h0, a}) * PRE_DIV2;
    chk(t2 - t1 >= w - 2 && t2 - t1 <= w + 2, 1'b1, "pulse width");
    $display("test one pulse done");
    // Repeating wave; counter restarted so the period starts clean
    a = 8'(4 + {$random(seed)} % 16);
    b = a + 8'(12 + {$random(seed)} % 16);
    bus_wr(OFS_CMPA_LO, a);
    bus_wr(OFS_CMPB_HI, 8'h00);
    bus_wr(OFS_CMPB_LO, b);
    bus_wr(OFS_CTL1, 8'h01);
    bus_wr(OFS_MODE, 8'h94);
    bus_wr(OFS_CNT_LO, 8'h00);
    // A stray match before the restart may leave the pin high: skip a fall
    wait_pin(1'b1, w);
    wait_pin(1'b0, w);
    wait_pin(1'b1, t1);
    wait_pin(1'b0, t2);
    wait_pin(1'b1, t3);
    chk(16'(t2 - t1), 16'((b - a) * 2), "wave high time");
    chk(16'(t3 - t1), 16'((b + 4) * 2), "wave period");
    stat_bit(7, 1'b1, "period end flag");
    bus_wr(OFS_MODE, 8'h00);
    $display("test wave done");
    // Captures on both pins and both edge choices
    for (int i = 0; i < 4; i++) begin
      if (i[1]) bus_wr(OFS_MODE, {6'h0, i[0], 1'b0});
      else bus_wr(OFS_CTL1, {6'h0, i[0], 1'b0});
      if (i[1]) cap_b <= i[0];
      else cap_a <= i[0];
      repeat (8) @(posedge hclk);
      bus_rd(OFS_STAT, v1);
      bus_rd(i[1] ? OFS_CAPB_LO : OFS_CAPA_LO, v1);
      if (i[1]) cap_b <= ~i[0];
      else cap_a <= ~i[0];
      repeat (8) @(posedge hclk);
      stat_bit(i[1] ? 4 : 7, 1'b0, "wrong edge");
      if (i[1]) cap_b <= i[0];
      else cap_a <= i[0];
      repeat (8) @(posedge hclk);
      stat_bit(i[1] ? 4 : 7, 1'b1, "capture edge");
    end
    $display("test captures done");
    // Prescaler rates, tolerance of one tick for the divider phase
    for (int i = 0; i < 3; i++) begin
      bus_wr(OFS_MODE, {4'h0, sels[i], 2'h0});
      bus_rd(OFS_CNT_LO, v1);
      t1 = cyc;
      repeat (64) @(posedge hclk);
      bus_rd(OFS_CNT_LO, v2);
      w = (cyc - t1) / divs[i];
      t2 = int'(8'(v2 - v1));
      chk(t2 >= w - 1 && t2 <= w + 1, 1'b1, "tick rate");
    end
    // External clock: one rise then one fall, count per chosen edge
    for (int e = 0; e < 2; e++) begin
      bus_wr(OFS_MODE, {4'h0, CLK_EXT, 1'b0, e[0]});
      bus_rd(OFS_CNT_LO, v1);
      ext_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      bus_rd(OFS_CNT_LO, v2);
      ext_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      bus_rd(OFS_CNT_LO, v3);
      chk(8'(v2 - v1), {7'h0, e[0]}, "rise count");
      chk(8'(v3 - v2), {7'h0, ~e[0]}, "fall count");
    end
    $display("test clocks done");
    // Wrap flag, interrupt and the clear sequence
    bus_wr(OFS_CTL1, 8'h20);
    bus_wr(OFS_MODE, 8'h04);
    bus_rd(OFS_STAT, v1);
    bus_rd(OFS_CNT_LO, v1);
    bus_wr(OFS_CNT_LO, 8'h00);
    repeat (20) @(posedge hclk);
    stat_bit(5, 1'b1, "wrap flag");
    chk(irq, 1'b1, "irq raised");
    bus_rd(OFS_ALT_LO, v1);
    stat_bit(5, 1'b1, "alt low kept flag");
    bus_rd(OFS_CNT_LO, v1);
    stat_bit(5, 1'b0, "wrap cleared");
    repeat (2) @(posedge hclk);
    chk(irq, 1'b0, "irq dropped");
    $display("test wrap done");
    // Compare matches drive both pins
    a = 8'(5 + {$random(seed)} % 16);
    b = a + 8'h3c;
    bus_wr(OFS_CTL1, 8'h05);
    bus_wr(OFS_CMPA_LO, a);
    bus_wr(OFS_CMPB_LO, b);
    bus_wr(OFS_MODE, 8'hc4);
    bus_rd(OFS_STAT, v1);
    bus_rd(OFS_CMPA_LO, v1);
    bus_rd(OFS_CMPB_LO, v1);
    bus_wr(OFS_CNT_LO, 8'h00);
    repeat (ticks_to({8'h0, a}) * PRE_DIV2 + 12) @(posedge hclk);
    bus_rd(OFS_STAT, v1);
    chk(v1[6], 1'b1, "match a flag");
    chk(v1[3], 1'b0, "early b flag");
    chk({pa, pa_oe_n}, 2'b10, "pin a level");
    repeat (140) @(posedge hclk);
    stat_bit(3, 1'b1, "match b flag");
    chk({pb, pb_oe_n}, 2'b10, "pin b level");
    // Force bits copy both levels at once; capture and compare irq groups enabled
    bus_wr(OFS_CTL1, 8'hd8);
    repeat (2) @(posedge hclk);
    chk({pa, pb}, 2'b00, "forced levels");
    chk(irq, 1'b1, "compare irq");
    $display("test compare done");
    // Disable freezes, releases pins, keeps registers reachable
    bus_wr(OFS_STAT, 8'h04);
    repeat (2) @(posedge hclk);
    bus_rd(OFS_STAT, v1);
    chk(v1[2:0], 3'b100, "status low bits");
    chk({pa_oe_n, pb_oe_n}, 2'b11, "pins released");
    bus_wr(OFS_CNT_LO, 8'h00);
    bus_rd(OFS_CNT_LO, v2);
    chk(v2, CNT_RST[7:0], "counter reset");
    repeat (40) @(posedge hclk);
    bus_rd(OFS_CNT_LO, v3);
    chk(v3, v2, "counter frozen");
    for (int i = 0; i < 4; i++) begin
      a = 8'($random(seed));
      bus_wr(i[0] ? OFS_CMPB_HI : OFS_CMPA_LO, a);
      bus_rd(i[0] ? OFS_CMPB_HI : OFS_CMPA_LO, v1);
      chk(v1, a, "write while disabled");
    end
    $display("test disable done");
    summarize();
  end
endmodule : tcsu_tb
